// ==== design/cism_pkg.sv ====
// Constants and types shared by the interrupt source map and its event registers
package cism_pkg;
  localparam int CISM_LINES = 16;
  localparam int CISM_EVT_W = 32;
  localparam int CISM_CODE_W = 3;
  // Core interrupt line positions
  localparam int CISM_L_RESET = 0;
  localparam int CISM_L_NMI = 1;
  localparam int CISM_L_RSV2 = 2;
  localparam int CISM_L_RSV3 = 3;
  localparam int CISM_L_TMR0 = 4;
  localparam int CISM_L_TMRX = 5;
  localparam int CISM_L_HOST = 6;
  localparam int CISM_L_FIFO = 7;
  localparam int CISM_L_DONE = 8;
  localparam int CISM_L_EVT_LO = 9;
  localparam int CISM_L_SERIAL = 14;
  localparam int CISM_L_EVT7 = 15;
  // Event entry interrupt codes
  localparam logic [2:0] CISM_CODE_LO = 3'h2;
  localparam logic [2:0] CISM_CODE_HI = 3'h6;
  localparam logic [2:0] CISM_CODE_15 = 3'h7;
  localparam int CISM_N_EVT_LINES = 5;
  // Values after reset
  localparam logic [15:0] CISM_IRQ_RST = 16'h0000;
  localparam logic [31:0] CISM_EVT_RST = 32'h0000_0000;
  localparam logic [1:0] CISM_RSYNC_RST = 2'h0;

  typedef struct packed {
    logic [15:0] irq;
    logic live;
  } cism_map_t;

  typedef struct packed {
    logic [31:0] trig;
    logic trig_stb;
    logic [31:0] stat;
    logic live;
  } cism_evt_t;
endpackage : cism_pkg

// ==== design/cism_evt_if.sv ====
// Carrier between the source map and the core-to-accelerator event registers
`timescale 1ns/1ps
interface cism_evt_if;
  logic trig_wr;
  logic [31:0] trig_wdata;
  logic stat_clr_wr;
  logic [31:0] stat_clr_mask;
  logic [31:0] stat_set;
  logic [31:0] trig_q;
  logic trig_stb;
  logic [31:0] stat_q;
  modport map (output trig_wr, trig_wdata, stat_clr_wr, stat_clr_mask, stat_set,
               input trig_q, trig_stb, stat_q);
  modport regs (input trig_wr, trig_wdata, stat_clr_wr, stat_clr_mask, stat_set,
                output trig_q, trig_stb, stat_q);
endinterface : cism_evt_if

// ==== design/cism_evt_regs.sv ====
// Event trigger and event status registers between core and DMA accelerator
`timescale 1ns/1ps
module cism_evt_regs
  import cism_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  cism_evt_if.regs evt
);
  cism_evt_t s_r;
  cism_evt_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.live = 1'b1;
    s_nxt.trig_stb = evt.trig_wr;
    if (evt.trig_wr) begin
      s_nxt.trig = evt.trig_wdata;
    end
    // Set beats clear so an event landing on a clear is kept
    s_nxt.stat = (s_r.stat & ~(evt.stat_clr_wr ? evt.stat_clr_mask : CISM_EVT_RST))
                 | evt.stat_set;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '{trig: CISM_EVT_RST, trig_stb: 1'b0, stat: CISM_EVT_RST, live: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign evt.trig_q = s_r.trig;
  assign evt.trig_stb = s_r.trig_stb;
  assign evt.stat_q = s_r.stat;

  // Checks wait for live: an input on the release edge is loaded but never checked
  trig_load_a: assert property (@(posedge ref_clk) disable iff (!s_r.live)
    evt.trig_wr |=> evt.trig_stb && evt.trig_q == $past(evt.trig_wdata))
    else $error("trigger write not presented to accelerator");
  stat_set_a: assert property (@(posedge ref_clk) disable iff (!s_r.live)
    evt.stat_set[0] |=> evt.stat_q[0])
    else $error("status event lost under clear");
  stat_clr_a: assert property (@(posedge ref_clk) disable iff (!s_r.live)
    evt.stat_clr_wr && evt.stat_clr_mask[0] && !evt.stat_set[0] |=> !evt.stat_q[0])
    else $error("status bit not cleared");
endmodule : cism_evt_regs

// ==== design/cism_top.sv ====
// Peripheral interrupt source map onto the sixteen core interrupt lines
`timescale 1ns/1ps
module cism_top
  import cism_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic reset_req,
  input wire logic dma_nmi_irq,
  input wire logic emc_irq,
  input wire logic [3:0] tmr_irq,
  input wire logic [1:0] tmr_ovf_irq,
  input wire logic host_cpu_irq,
  input wire logic dma_fifo_irq,
  input wire logic dma_done_irq,
  input wire logic dma_evt_valid,
  input wire logic [2:0] dma_evt_code,
  input wire logic dma_evt_cpu_req,
  input wire logic [1:0] twi_irq,
  input wire logic [1:0] ssp_irq,
  input wire logic core_trig_wr,
  input wire logic [31:0] core_trig_wdata,
  input wire logic core_stat_clr_wr,
  input wire logic [31:0] core_stat_clr_mask,
  input wire logic [31:0] dma_stat_set,
  output logic [15:0] core_irq,
  output logic [31:0] dma_trig_data,
  output logic dma_trig_stb,
  output logic [31:0] core_evt_status
);
  logic [1:0] rsync_r;
  logic rst_n;
  cism_map_t s_r;
  cism_map_t s_nxt;
  logic evt_ok;

  // Reset released through two flops so removal is clean in this domain
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rsync_r <= CISM_RSYNC_RST;
    end else begin
      rsync_r <= {rsync_r[0], 1'b1};
    end
  end
  assign rst_n = rsync_r[1];

  assign evt_ok = dma_evt_valid && dma_evt_cpu_req;

  always_comb begin
    s_nxt = s_r;
    s_nxt.irq[CISM_L_RESET] = reset_req;
    s_nxt.irq[CISM_L_NMI] = dma_nmi_irq | emc_irq;
    s_nxt.irq[CISM_L_RSV2] = 1'b0;
    s_nxt.irq[CISM_L_RSV3] = 1'b0;
    s_nxt.irq[CISM_L_TMR0] = tmr_irq[0];
    s_nxt.irq[CISM_L_TMRX] = (|tmr_irq[3:1]) | (|tmr_ovf_irq);
    s_nxt.irq[CISM_L_HOST] = host_cpu_irq;
    s_nxt.irq[CISM_L_FIFO] = dma_fifo_irq;
    s_nxt.irq[CISM_L_DONE] = dma_done_irq;
    // One line per code, ascending
    for (int k = 0; k < CISM_N_EVT_LINES; k++) begin
      s_nxt.irq[CISM_L_EVT_LO + k] = evt_ok && (dma_evt_code == CISM_CODE_LO + 3'(k));
    end
    // Line 14 belongs to the serial ports, so code 7 skips it
    s_nxt.irq[CISM_L_SERIAL] = (|twi_irq) | (|ssp_irq);
    s_nxt.irq[CISM_L_EVT7] = evt_ok && (dma_evt_code == CISM_CODE_15);
    s_nxt.live = 1'b1; // Checks arm one edge after the lines leave reset
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '{irq: CISM_IRQ_RST, live: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign core_irq = s_r.irq;

  cism_evt_if evt ();
  assign evt.trig_wr = core_trig_wr;
  assign evt.trig_wdata = core_trig_wdata;
  assign evt.stat_clr_wr = core_stat_clr_wr;
  assign evt.stat_clr_mask = core_stat_clr_mask;
  assign evt.stat_set = dma_stat_set;

  cism_evt_regs u_evt (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .evt(evt.regs)
  );

  assign dma_trig_data = evt.trig_q;
  assign dma_trig_stb = evt.trig_stb;
  assign core_evt_status = evt.stat_q;

  reset_line_a: assert property (@(posedge ref_clk) disable iff (!s_r.live)
    reset_req |=> core_irq[CISM_L_RESET])
    else $error("reset request not on line 0");

  reset_only_a: assert property (@(posedge ref_clk) disable iff (!s_r.live)
    core_irq[CISM_L_RESET] |-> $past(reset_req))
    else $error("line 0 raised without reset request");

  rsv_idle_a: assert property (@(posedge ref_clk) disable iff (!s_r.live)
    core_irq[CISM_L_RSV3:CISM_L_RSV2] == 2'h0)
    else $error("reserved line active");

  nmi_or_a: assert property (@(posedge ref_clk) disable iff (!s_r.live)
    (dma_nmi_irq || emc_irq) |=> core_irq[CISM_L_NMI])
    else $error("nmi line missed a source");

  nmi_only_a: assert property (@(posedge ref_clk) disable iff (!s_r.live)
    core_irq[CISM_L_NMI] |-> $past(dma_nmi_irq || emc_irq))
    else $error("nmi line raised without source");

  timer0_line_a: assert property (@(posedge ref_clk) disable iff (!s_r.live)
    tmr_irq[0] |=> core_irq[CISM_L_TMR0])
    else $error("timer 0 not on line 4");

  timer0_only_a: assert property (@(posedge ref_clk) disable iff (!s_r.live)
    core_irq[CISM_L_TMR0] |-> $past(tmr_irq[0]))
    else $error("line 4 raised without timer 0");

  timer_or_a: assert property (@(posedge ref_clk) disable iff (!s_r.live)
    ((|tmr_irq[3:1]) || (|tmr_ovf_irq)) |=> core_irq[CISM_L_TMRX])
    else $error("line 5 missed a timer source");

  timer_only_a: assert property (@(posedge ref_clk) disable iff (!s_r.live)
    core_irq[CISM_L_TMRX] |-> $past((|tmr_irq[3:1]) || (|tmr_ovf_irq)))
    else $error("line 5 without timer source");

  host_line_a: assert property (@(posedge ref_clk) disable iff (!s_r.live)
    host_cpu_irq |=> core_irq[CISM_L_HOST])
    else $error("host request not on line 6");

  host_only_a: assert property (@(posedge ref_clk) disable iff (!s_r.live)
    core_irq[CISM_L_HOST] |-> $past(host_cpu_irq))
    else $error("line 6 raised without host request");

  fifo_line_a: assert property (@(posedge ref_clk) disable iff (!s_r.live)
    dma_fifo_irq |=> core_irq[CISM_L_FIFO])
    else $error("fifo status not on line 7");

  fifo_only_a: assert property (@(posedge ref_clk) disable iff (!s_r.live)
    core_irq[CISM_L_FIFO] |-> $past(dma_fifo_irq))
    else $error("line 7 raised without fifo status");

  done_line_a: assert property (@(posedge ref_clk) disable iff (!s_r.live)
    dma_done_irq |=> core_irq[CISM_L_DONE])
    else $error("completion not on line 8");

  done_only_a: assert property (@(posedge ref_clk) disable iff (!s_r.live)
    core_irq[CISM_L_DONE] |-> $past(dma_done_irq))
    else $error("line 8 not tied to completion");

  evt_gate_a: assert property (@(posedge ref_clk) disable iff (!s_r.live)
    !(dma_evt_valid && dma_evt_cpu_req) |=> core_irq[13:9] == 5'h0 && !core_irq[CISM_L_EVT7])
    else $error("event line raised without request");

  code_low_a: assert property (@(posedge ref_clk) disable iff (!s_r.live)
    evt_ok && dma_evt_code < 3'h2 |=> core_irq[15] == 1'b0 && core_irq[13:9] == 5'h00)
    else $error("code below 2 raised an event line");

  code2_line_a: assert property (@(posedge ref_clk) disable iff (!s_r.live)
    evt_ok && dma_evt_code == 3'h2 |=> core_irq[13:9] == 5'h01)
    else $error("code 2 not on line 9");

  code3_line_a: assert property (@(posedge ref_clk) disable iff (!s_r.live)
    evt_ok && dma_evt_code == 3'h3 |=> core_irq[13:9] == 5'h02)
    else $error("code 3 not on line 10");

  code4_line_a: assert property (@(posedge ref_clk) disable iff (!s_r.live)
    evt_ok && dma_evt_code == 3'h4 |=> core_irq[13:9] == 5'h04)
    else $error("code 4 not on line 11");

  code5_line_a: assert property (@(posedge ref_clk) disable iff (!s_r.live)
    evt_ok && dma_evt_code == 3'h5 |=> core_irq[13:9] == 5'h08)
    else $error("code 5 not on line 12");

  code6_line_a: assert property (@(posedge ref_clk) disable iff (!s_r.live)
    evt_ok && dma_evt_code == 3'h6 |=> core_irq[13:9] == 5'h10)
    else $error("code 6 not on line 13");

  code7_line_a: assert property (@(posedge ref_clk) disable iff (!s_r.live)
    evt_ok && dma_evt_code == 3'h7 && twi_irq == 2'h0 && ssp_irq == 2'h0
    |=> core_irq[CISM_L_EVT7] && !core_irq[CISM_L_SERIAL])
    else $error("code 7 misrouted");

  evt_onehot_a: assert property (@(posedge ref_clk) disable iff (!s_r.live)
    $onehot0({core_irq[CISM_L_EVT7], core_irq[13:9]}))
    else $error("more than one event line raised");

  serial_or_a: assert property (@(posedge ref_clk) disable iff (!s_r.live)
    ((|twi_irq) || (|ssp_irq)) |=> core_irq[CISM_L_SERIAL])
    else $error("serial request not on line 14");

  serial_only_a: assert property (@(posedge ref_clk) disable iff (!s_r.live)
    core_irq[CISM_L_SERIAL] |-> $past((|twi_irq) || (|ssp_irq)))
    else $error("line 14 raised without serial request");

  trig_out_a: assert property (@(posedge ref_clk) disable iff (!s_r.live)
    dma_trig_stb |-> $past(core_trig_wr))
    else $error("trigger strobe without core write");

  trig_hold_a: assert property (@(posedge ref_clk) disable iff (!s_r.live)
    !core_trig_wr |=> !dma_trig_stb && $stable(dma_trig_data))
    else $error("trigger value moved without core write");

  stat_hold_a: assert property (@(posedge ref_clk) disable iff (!s_r.live)
    !core_stat_clr_wr && dma_stat_set == 32'h0000_0000 |=> $stable(core_evt_status))
    else $error("event status moved without set or clear");
endmodule : cism_top

// ==== testbench/cism_core_model.sv ====
// Core-side model that latches rising interrupt lines as pending
`timescale 1ns/1ps
module cism_core_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [15:0] core_irq,
  input wire logic [15:0] ack,
  output logic [15:0] pending
);
  logic [15:0] prev_r;
  logic [15:0] pending_r;
  // Edge capture: a held line is taken once, so software must ack it
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_r <= 16'h0000;
      pending_r <= 16'h0000;
    end else begin
      prev_r <= core_irq;
      pending_r <= (pending_r & ~ack) | (core_irq & ~prev_r);
    end
  end
  assign pending = pending_r;
endmodule : cism_core_model

// ==== testbench/cpu_interrupt_source_map_bench.sv ====
// Self-checking bench for the interrupt source map
`timescale 1ns/1ps
module cpu_interrupt_source_map_bench;
  logic clk = 1'b0, rst_n = 1'b0, ev_v = 1'b0, ev_req = 1'b0, twr = 1'b0, cwr = 1'b0;
  logic [15:0] src = 16'h0000, ack = 16'h0000, irq, pend;
  logic [2:0] ev_code = 3'h0;
  logic [31:0] twd = 32'h0, cmask = 32'h0, sset = 32'h0, tdata, stat;
  logic tstb;
  int mismatches = 0, comparisons = 0, cyc = 0;
  // Line reached by each source bit of src
  int lin[16] = '{0, 1, 1, 4, 5, 5, 5, 5, 5, 6, 7, 8, 14, 14, 14, 14};
  always #2 clk = ~clk;
  cism_top u_cism_top (.ref_clk(clk), .reset_n(rst_n), .reset_req(src[0]),
    .dma_nmi_irq(src[1]), .emc_irq(src[2]), .tmr_irq(src[6:3]), .tmr_ovf_irq(src[8:7]),
    .host_cpu_irq(src[9]), .dma_fifo_irq(src[10]), .dma_done_irq(src[11]),
    .dma_evt_valid(ev_v), .dma_evt_code(ev_code), .dma_evt_cpu_req(ev_req),
    .twi_irq(src[13:12]), .ssp_irq(src[15:14]), .core_trig_wr(twr), .core_trig_wdata(twd),
    .core_stat_clr_wr(cwr), .core_stat_clr_mask(cmask), .dma_stat_set(sset),
    .core_irq(irq), .dma_trig_data(tdata), .dma_trig_stb(tstb), .core_evt_status(stat));
  cism_core_model u_cism_core_model (.ref_clk(clk), .rst_n(rst_n), .core_irq(irq),
    .ack(ack), .pending(pend));
  task automatic chk(string n, logic [31:0] got, logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, exp, got);
    end
  endtask : chk
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask : settle
  task automatic finish_test;
    if (mismatches == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test
  task automatic t_map;
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      src <= 16'h1 << i;
      ack <= 16'h0000;
      settle();
      chk("irq", {16'h0, irq}, 32'h1 << lin[i]);
      chk("pend", {31'h0, pend[lin[i]]}, 32'h1);
      @(posedge clk);
      src <= 16'h0000;
      ack <= 16'hFFFF;
      settle();
    end
  endtask : t_map
  task automatic t_evt;
    logic [31:0] exp;
    for (int r = 0; r < 2; r++) begin
      for (int c = 0; c < 8; c++) begin
        @(posedge clk);
        ev_v <= 1'b1;
        ev_req <= r[0];
        ev_code <= c[2:0];
        settle();
        exp = (r == 1 && c >= 2) ? ((c == 7) ? 32'h8000 : 32'h1 << (c + 7)) : 32'h0;
        chk("evt", {16'h0, irq}, exp);
      end
    end
    @(posedge clk);
    ev_v <= 1'b0;
    settle();
    chk("evt_off", {16'h0, irq}, 32'h0);
  endtask : t_evt
  task automatic t_or;
    @(posedge clk);
    src <= 16'hFFFF;
    {ev_v, ev_req, ev_code} <= 5'h1F;
    settle();
    chk("all", {16'h0, irq}, 32'h0000_C1F3);
    @(posedge clk);
    src <= 16'h0000;
    ev_v <= 1'b0;
    settle();
  endtask : t_or
  task automatic t_trig;
    @(posedge clk);
    twr <= 1'b1;
    twd <= 32'hA5A5_0001;
    @(posedge clk);
    twd <= 32'h5A5A_0002;
    #1;
    chk("tstb", {31'h0, tstb}, 32'h1);
    chk("tdata", tdata, 32'hA5A5_0001);
    @(posedge clk);
    twr <= 1'b0;
    #1;
    chk("tdata", tdata, 32'h5A5A_0002);
    @(posedge clk);
    #1;
    chk("tstb", {31'h0, tstb}, 32'h0);
  endtask : t_trig
  task automatic t_stat;
    @(posedge clk);
    sset <= 32'h8000_0001;
    @(posedge clk);
    sset <= 32'h0;
    #1;
    chk("stat", stat, 32'h8000_0001);
    @(posedge clk);
    {cwr, cmask, sset} <= {1'b1, 32'h8000_0001, 32'h0000_0001};
    @(posedge clk);
    {cwr, sset} <= {1'b0, 32'h0};
    settle();
    chk("stat", stat, 32'h0000_0001);
    @(posedge clk);
    {cwr, cmask} <= {1'b1, 32'h0000_0001};
    @(posedge clk);
    cwr <= 1'b0;
    #1;
    chk("stat_clr", stat, 32'h0);
  endtask : t_stat
  task automatic t_rst;
    @(posedge clk);
    src <= 16'h0200;
    settle();
    chk("pre_rst", {16'h0, irq}, 32'h0000_0040);
    @(posedge clk);
    rst_n <= 1'b0;
    #1;
    chk("in_rst", {16'h0, irq}, 32'h0);
    chk("rst_tdata", tdata, 32'h0);
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk("rst_e2", {16'h0, irq}, 32'h0);
    @(posedge clk);
    #1;
    chk("rst_e3", {16'h0, irq}, 32'h0000_0040);
    @(posedge clk);
    src <= 16'h0000;
    settle();
  endtask : t_rst
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      finish_test();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("rst", {16'h0, irq}, 32'h0);
    t_map();
    t_evt();
    t_or();
    t_trig();
    t_stat();
    t_rst();
    finish_test();
  end
endmodule : cpu_interrupt_source_map_bench
